// file: pkg/ifs_pkg.sv
// Package of the inverter fault supervisor: register map, fault codes, limits, timing.
// Assumes a 40 MHz system clock and a 32-bit APB register bus.
`default_nettype none
package ifs_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned TICK_S = 1;
    localparam int unsigned CYC_PER_S = CLK_HZ * TICK_S;
    localparam int unsigned RECUR_S = 30;

    // Byte offsets
    localparam logic [7:0] OFS_ALARM    = 8'h00;
    localparam logic [7:0] OFS_FAULT    = 8'h04;
    localparam logic [7:0] OFS_LAST     = 8'h08;
    localparam logic [7:0] OFS_SECOND   = 8'h0c;
    localparam logic [7:0] OFS_THIRD    = 8'h10;
    localparam logic [7:0] OFS_CURR     = 8'h14;
    localparam logic [7:0] OFS_VOLT     = 8'h18;
    localparam logic [7:0] OFS_FREQ     = 8'h1c;
    localparam logic [7:0] OFS_TEMP     = 8'h20;
    localparam logic [7:0] OFS_AR_DELAY = 8'h24;
    localparam logic [7:0] OFS_ENC_MASK = 8'h28;
    localparam logic [7:0] OFS_SPD_REF  = 8'h2c;
    localparam logic [7:0] OFS_OUT_SPD  = 8'h30;
    localparam logic [7:0] OFS_MOT_CUR  = 8'h34;
    localparam logic [7:0] OFS_CONTROL  = 8'h38;

    localparam logic [15:0] AR_DELAY_RST = 16'h0000;
    localparam logic [1:0]  ENC_MASK_RST = 2'h3;
    localparam logic [1:0]  PIN_SYNC_RST = 2'h3;

    // Control bits
    localparam int unsigned CTL_SUPPLY_HI = 0;
    localparam int unsigned CTL_FAULT_RST = 1;

    // Fault and alarm codes
    localparam logic [15:0] F_LINK_LOW   = 16'd21;
    localparam logic [15:0] F_LINK_HIGH  = 16'd22;
    localparam logic [15:0] F_TUNING     = 16'd33;
    localparam logic [15:0] F_ENC_WIRING = 16'd67;
    localparam logic [15:0] F_OVERCURR   = 16'd70;
    localparam logic [15:0] F_ENC_SIGNAL = 16'd79;
    localparam logic [15:0] F_EXEC       = 16'd80;
    localparam logic [15:0] F_USER_SAVE  = 16'd81;
    localparam logic [15:0] F_COPY       = 16'd82;
    localparam logic [15:0] F_HW_ID      = 16'd84;
    localparam logic [15:0] F_EXT        = 16'd91;
    localparam logic [15:0] F_KEYPAD     = 16'd701;
    localparam logic [15:0] A_EXT        = 16'd90;
    localparam logic [15:0] A_KEYPAD     = 16'd700;

    // DC link limits in volts
    localparam logic [15:0] LOW_LVL_115  = 16'd230;
    localparam logic [15:0] HIGH_LVL_115 = 16'd460;
    localparam logic [15:0] LOW_LVL_230  = 16'd200;
    localparam logic [15:0] HIGH_LVL_230 = 16'd410;

    localparam logic [3:0] SAVE_LIMIT      = 4'd0;
    localparam logic [7:0] MAX_USER_DIFFS  = 8'd32;
    localparam logic [1:0] RECUR_LIMIT     = 2'd3;
endpackage : ifs_pkg
`default_nettype wire

// file: hw/ifs_supervisor.sv
// Inverter fault supervisor: fault detection, history, auto-reset, APB registers.
// Assumes event inputs are pulses or levels from the same clock, except pins.
// Functional notes
// - Phase overcurrent cuts PWM at once and reports fault 70.
// - Low supply range: link low fault at 230 V, high at 460 V.
// - High supply range: link low fault at 200 V, high at 410 V.
// - VV-mode tuning or manual stator resistance too high raises fault 33.
// - Broken keypad link raises alarm 700.
// - Keypad link loss with keypad as source also raises fault 701.
// - Failed hardware identification on default load raises fault 84.
// - Detected execution monitor fault raises fault 80.
// - User save fails with fault 81 above 32 changes or write protected.
// - Copy with different major version refused with fault 82.
// - Inactive external alarm input raises alarm 90; motor keeps running.
// - Inactive external fault input raises fault 91 and cuts PWM.
// - Three latest fault numbers kept; current, voltage, frequency, temperature for the latest only.
// - Active alarm and fault numbers readable, range 0 to 999.
// - Last, second and third fault numbers readable separately.
// - Snapshots hold current, link voltage, frequency and temperature values.
// - Auto-reset after delay seconds except fault 67; zero disables.
// - Same fault three times within 30 s after reset locks auto-reset.
// - Encoder mask 0 none, 1 wiring, 2 signal, 3 both; default 3.
// - Status registers are read-only; writes ignored.
// - Any fault blocks the power switches.
`default_nettype none
module ifs_supervisor
    import ifs_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        overcurrent_pin_i,
    input  wire logic        ext_alarm_pin_i,
    input  wire logic        ext_fault_pin_i,
    input  wire logic        ext_alarm_en_i,
    input  wire logic        ext_fault_en_i,
    input  wire logic        keypad_link_ok_i,
    input  wire logic        keypad_is_source_i,
    input  wire logic        tuning_done_i,
    input  wire logic        tuning_mode_vv_i,
    input  wire logic        stator_res_edit_i,
    input  wire logic [15:0] stator_res_i,
    input  wire logic [15:0] stator_res_max_i,
    input  wire logic        hw_identify_fail_i,
    input  wire logic        default_load_i,
    input  wire logic        exec_fault_i,
    input  wire logic        user_save_req_i,
    input  wire logic [7:0]  user_diff_count_i,
    input  wire logic        user_save_wp_i,
    input  wire logic        copy_req_i,
    input  wire logic [7:0]  copy_ver_i,
    input  wire logic [7:0]  own_ver_i,
    input  wire logic        enc_wiring_det_i,
    input  wire logic        enc_signal_det_i,
    input  wire logic [15:0] link_voltage_i,
    input  wire logic [15:0] out_current_i,
    input  wire logic [15:0] out_freq_i,
    input  wire logic [15:0] module_temp_i,
    input  wire logic [15:0] speed_ref_i,
    input  wire logic [15:0] out_speed_i,
    output logic             pwm_enable_o,
    output logic             fault_active_o
);
    typedef struct packed {
        logic [1:0]  rst_sync;
        logic [1:0]  oc_sync;
        logic [1:0]  xa_sync;
        logic [1:0]  xf_sync;
        logic [15:0] alarm;
        logic [15:0] fault;
        logic [2:0][15:0] hist;
        logic [15:0] snap_cur;
        logic [15:0] snap_volt;
        logic [15:0] snap_freq;
        logic [15:0] snap_temp;
        logic [15:0] ar_delay;
        logic [1:0]  enc_mask;
        logic        supply_hi;
        logic [31:0] prescale;
        logic [7:0]  ar_secs;
        logic [7:0]  since_reset;
        logic        reset_recent;
        logic [1:0]  repeat_cnt;
        logic        ar_locked;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        pwm_en;
        logic        fault_flag;
    } ifs_state_t;

    ifs_state_t st;
    ifs_state_t next_st;
    logic       rst_n;
    assign rst_n = st.rst_sync[1];

    function automatic logic [15:0] ifs_pick_fault(input logic oc, input logic xf,
                                                    input logic [15:0] code_lo);
        if (oc) begin
            return F_OVERCURR;
        end else if (xf) begin
            return F_EXT;
        end
        return code_lo;
    endfunction : ifs_pick_fault

    logic        lim_low;
    logic        lim_high;
    logic [15:0] new_code;
    logic        hw_trip;
    logic        fault_reset;
    logic        apb_wr;
    logic        apb_rd;

    always_comb begin
        lim_low  = st.supply_hi ? (link_voltage_i < LOW_LVL_230)
                                : (link_voltage_i < LOW_LVL_115);
        lim_high = st.supply_hi ? (link_voltage_i > HIGH_LVL_230)
                                : (link_voltage_i > HIGH_LVL_115);
        hw_trip  = st.oc_sync[1] || (ext_fault_en_i && !st.xf_sync[1]);
        new_code = 16'h0000;
        if (exec_fault_i) begin
            new_code = F_EXEC;
        end else if (default_load_i && hw_identify_fail_i) begin
            new_code = F_HW_ID;
        end else if (user_save_req_i && (user_diff_count_i > MAX_USER_DIFFS
                                         || user_save_wp_i)) begin
            new_code = F_USER_SAVE;
        end else if (copy_req_i && copy_ver_i[7:4] != own_ver_i[7:4]) begin
            new_code = F_COPY;
        end else if (((tuning_done_i && tuning_mode_vv_i) || stator_res_edit_i)
                     && stator_res_i > stator_res_max_i) begin
            new_code = F_TUNING;
        end else if (!keypad_link_ok_i && keypad_is_source_i) begin
            new_code = F_KEYPAD;
        end else if (enc_wiring_det_i && st.enc_mask[0]) begin
            new_code = F_ENC_WIRING;
        end else if (enc_signal_det_i && st.enc_mask[1]) begin
            new_code = F_ENC_SIGNAL;
        end else if (lim_low) begin
            new_code = F_LINK_LOW;
        end else if (lim_high) begin
            new_code = F_LINK_HIGH;
        end
        new_code = ifs_pick_fault(st.oc_sync[1],
                                  ext_fault_en_i && !st.xf_sync[1],
                                  new_code);
        apb_wr = psel_i && penable_i && pwrite_i;
        apb_rd = psel_i && penable_i && !pwrite_i;
        // Acts only at the edge that completes the write
        fault_reset = apb_wr && st.pready && paddr_i == OFS_CONTROL
                      && pwdata_i[CTL_FAULT_RST];
    end

    always_comb begin
        next_st = st;
        next_st.rst_sync = {st.rst_sync[0], 1'b1};
        next_st.oc_sync  = {st.oc_sync[0], overcurrent_pin_i};
        next_st.xa_sync  = {st.xa_sync[0], ext_alarm_pin_i};
        next_st.xf_sync  = {st.xf_sync[0], ext_fault_pin_i};

        // Keypad alarm outranks the external one; alarm never stops the motor
        if (!keypad_link_ok_i) begin
            next_st.alarm = A_KEYPAD;
        end else if (ext_alarm_en_i && !st.xa_sync[1]) begin
            next_st.alarm = A_EXT;
        end else begin
            next_st.alarm = 16'h0000;
        end

        // Seconds tick drives auto-reset delay and recurrence window
        if (st.prescale == CYC_PER_S - 1) begin
            next_st.prescale = 32'h0;
            if (st.fault != 16'h0000 && st.ar_secs != 8'hff) begin
                next_st.ar_secs = st.ar_secs + 8'h01;
            end
            if (st.reset_recent) begin
                next_st.since_reset = st.since_reset + 8'h01;
                if (st.since_reset + 8'h01 >= 8'(RECUR_S)) begin
                    next_st.reset_recent = 1'b0;
                    next_st.repeat_cnt   = 2'h0;
                end
            end
        end else begin
            next_st.prescale = st.prescale + 32'h1;
        end

        if (st.fault == 16'h0000 && new_code != 16'h0000) begin
            next_st.fault     = new_code;
            next_st.hist[2]   = st.hist[1];
            next_st.hist[1]   = st.hist[0];
            next_st.hist[0]   = new_code;
            next_st.snap_cur  = out_current_i;
            next_st.snap_volt = link_voltage_i;
            next_st.snap_freq = out_freq_i;
            next_st.snap_temp = module_temp_i;
            next_st.ar_secs   = 8'h00;
            next_st.pwm_en    = 1'b0;
            if (st.reset_recent && new_code == st.hist[0]) begin
                next_st.repeat_cnt = st.repeat_cnt + 2'h1;
                if (st.repeat_cnt + 2'h1 >= RECUR_LIMIT - 2'h1) begin
                    next_st.ar_locked = 1'b1;
                end
            end else begin
                next_st.repeat_cnt = 2'h0;
            end
        end else if (st.fault != 16'h0000) begin
            next_st.pwm_en = 1'b0;
            if (!hw_trip && (fault_reset ||
                (st.ar_delay[7:0] != 8'h00 && !st.ar_locked &&
                 st.fault != F_ENC_WIRING &&
                 st.ar_secs >= st.ar_delay[7:0]))) begin
                next_st.fault        = 16'h0000;
                next_st.reset_recent = 1'b1;
                next_st.since_reset  = 8'h00;
                if (fault_reset) begin
                    next_st.ar_locked  = 1'b0;
                    next_st.repeat_cnt = 2'h0;
                end
            end
        end else begin
            next_st.pwm_en = 1'b1;
        end
        if (hw_trip) begin
            next_st.pwm_en = 1'b0;
        end
        // Registered copy so the fault output comes straight from a flip-flop
        next_st.fault_flag = next_st.fault != 16'h0000;

        // APB: single wait-free access, writes land in the access phase
        next_st.pready  = psel_i && !penable_i;
        next_st.pslverr = 1'b0;
        if (apb_wr && !st.pready) begin
            next_st.pready = 1'b1;
        end
        if (psel_i && penable_i && st.pready) begin
            next_st.pready = 1'b0;
            if (pwrite_i) begin
                if (paddr_i == OFS_AR_DELAY) begin
                    next_st.ar_delay = {8'h00, pwdata_i[7:0]};
                end else if (paddr_i == OFS_ENC_MASK) begin
                    next_st.enc_mask = pwdata_i[1:0];
                end else if (paddr_i == OFS_CONTROL) begin
                    next_st.supply_hi = pwdata_i[CTL_SUPPLY_HI];
                end
            end
        end
        next_st.prdata = 32'h0;
        if (psel_i && !penable_i && !pwrite_i) begin
            if (paddr_i == OFS_ALARM) begin
                next_st.prdata = {16'h0, st.alarm};
            end else if (paddr_i == OFS_FAULT) begin
                next_st.prdata = {16'h0, st.fault};
            end else if (paddr_i == OFS_LAST) begin
                next_st.prdata = {16'h0, st.hist[0]};
            end else if (paddr_i == OFS_SECOND) begin
                next_st.prdata = {16'h0, st.hist[1]};
            end else if (paddr_i == OFS_THIRD) begin
                next_st.prdata = {16'h0, st.hist[2]};
            end else if (paddr_i == OFS_CURR) begin
                next_st.prdata = {16'h0, st.snap_cur};
            end else if (paddr_i == OFS_VOLT) begin
                next_st.prdata = {16'h0, st.snap_volt};
            end else if (paddr_i == OFS_FREQ) begin
                next_st.prdata = {16'h0, st.snap_freq};
            end else if (paddr_i == OFS_TEMP) begin
                next_st.prdata = {16'h0, st.snap_temp};
            end else if (paddr_i == OFS_AR_DELAY) begin
                next_st.prdata = {16'h0, st.ar_delay};
            end else if (paddr_i == OFS_ENC_MASK) begin
                next_st.prdata = {30'h0, st.enc_mask};
            end else if (paddr_i == OFS_SPD_REF) begin
                next_st.prdata = {16'h0, speed_ref_i};
            end else if (paddr_i == OFS_OUT_SPD) begin
                next_st.prdata = {16'h0, out_speed_i};
            end else if (paddr_i == OFS_MOT_CUR) begin
                next_st.prdata = {16'h0, out_current_i};
            end else if (paddr_i == OFS_CONTROL) begin
                next_st.prdata = {28'h0, st.ar_locked, 2'h0, st.supply_hi};
            end else begin
                next_st.pslverr = 1'b1;
            end
        end else if (psel_i && !penable_i) begin
            // Writes to read-only offsets are ignored, not errored
            next_st.pslverr = !(paddr_i <= OFS_CONTROL && paddr_i[1:0] == 2'h0);
        end else if (psel_i && penable_i && !st.pready) begin
            next_st.prdata  = st.prdata;
            next_st.pslverr = st.pslverr;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st          <= '0;
            // External pins idle high: a zero would fake an alarm or fault
            st.xa_sync  <= PIN_SYNC_RST;
            st.xf_sync  <= PIN_SYNC_RST;
            st.ar_delay <= AR_DELAY_RST;
            st.enc_mask <= ENC_MASK_RST;
        end else if (!rst_n) begin
            st          <= '0;
            st.rst_sync <= next_st.rst_sync;
            st.xa_sync  <= PIN_SYNC_RST;
            st.xf_sync  <= PIN_SYNC_RST;
            st.ar_delay <= AR_DELAY_RST;
            st.enc_mask <= ENC_MASK_RST;
        end else begin
            st <= next_st;
        end
    end

    assign prdata_o       = st.prdata;
    assign pready_o       = st.pready;
    assign pslverr_o      = st.pslverr;
    assign pwm_enable_o   = st.pwm_en;
    assign fault_active_o = st.fault_flag;

    a_oc_cuts_pwm: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        st.oc_sync[1] |=> !pwm_enable_o) else $error("pwm not cut");
    a_ext_fault_cut: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (ext_fault_en_i && !st.xf_sync[1]) |=> !pwm_enable_o)
        else $error("ext fault pwm on");
    a_fault_blocks: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (st.fault != 16'h0000) |-> !pwm_enable_o) else $error("pwm in fault");
    a_keypad_alarm: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        !keypad_link_ok_i |=> st.alarm == A_KEYPAD) else $error("no keypad alarm");
    a_history_shift: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (st.fault == 16'h0000 && new_code != 16'h0000) |=>
        st.hist[1] == $past(st.hist[0]) && st.hist[2] == $past(st.hist[1]))
        else $error("history not shifted");
    a_wiring_no_auto: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (st.fault == F_ENC_WIRING && !fault_reset) |=> st.fault == F_ENC_WIRING)
        else $error("wiring fault auto reset");
    a_mask_off_enc: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (st.enc_mask == 2'h0) |-> new_code != F_ENC_WIRING && new_code != F_ENC_SIGNAL)
        else $error("masked encoder fault");
    a_low_limit: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (!st.supply_hi && link_voltage_i < 16'd230) |-> lim_low)
        else $error("low limit missed");
    // Recurrence lock, zero delay, last record, high limit, alarm run and the status read path
    a_lock_third: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (st.fault == 16'h0000 && new_code != 16'h0000 && st.reset_recent &&
         new_code == st.hist[0] && st.repeat_cnt == 2'h1) |=> st.ar_locked)
        else $error("no recurrence lock");
    a_lock_holds: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (st.ar_locked && st.fault != 16'h0000 && !fault_reset) |=> st.fault != 16'h0000)
        else $error("auto reset while locked");
    a_zero_delay: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (st.ar_delay[7:0] == 8'h00 && st.fault != 16'h0000 && !fault_reset) |=>
        $stable(st.fault)) else $error("auto reset with zero delay");
    a_last_record: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (st.fault == 16'h0000 && new_code != 16'h0000) |=>
        st.hist[0] == $past(new_code) && st.snap_volt == $past(link_voltage_i))
        else $error("last fault record wrong");
    a_high_limit: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (st.supply_hi && link_voltage_i > 16'd410) |-> lim_high)
        else $error("high limit missed");
    a_alarm_runs: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (st.fault == 16'h0000 && new_code == 16'h0000) |=> pwm_enable_o)
        else $error("alarm stopped pwm");
    a_fault_read: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (psel_i && !penable_i && !pwrite_i && paddr_i == OFS_FAULT) |=>
        prdata_o == {16'h0000, $past(st.fault)}) else $error("fault read wrong");
endmodule : ifs_supervisor
`default_nettype wire

// file: bench/ifs_plant_model.sv
// Far-side model: phase current pin, external inputs, keypad link, measurements.
// Assumes the bench drives the c_ fields on clock edges by non-blocking assignment.
`default_nettype none
module ifs_plant_model (
    output logic             oc_o,
    output logic             alarm_pin_o,
    output logic             fault_pin_o,
    output logic             link_ok_o,
    output logic      [15:0] volt_o,
    output logic      [47:0] meas_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // External inputs rest high: a low input is the alarm or fault state
    logic        c_oc = 1'h0, c_alarm = 1'h1, c_fault = 1'h1, c_link = 1'h1;
    logic [15:0] c_volt = 16'h012c;
    assign {oc_o, alarm_pin_o, fault_pin_o, link_ok_o} = {c_oc, c_alarm, c_fault, c_link};
    assign volt_o = c_volt;
    // Current, frequency and temperature stand still so snapshots are predictable
    assign meas_o = {16'h007b, 16'h0258, 16'h01c2};
endmodule : ifs_plant_model
`default_nettype wire

// file: bench/tb_inverter_fault_supervisor.sv
// Bench for the inverter fault supervisor: register map, fault paths and history.
// Assumes the plant model drives pins and measurements; this module is the APB master.
`default_nettype none
module tb_inverter_fault_supervisor
    import ifs_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk_i = 1'h0, nrst_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
    logic        ext_alarm_en_i = 1'h0, ext_fault_en_i = 1'h0, keypad_is_source_i = 1'h0;
    logic        tuning_done_i = 1'h0, tuning_mode_vv_i = 1'h0, stator_res_edit_i = 1'h0;
    logic        hw_identify_fail_i = 1'h0, default_load_i = 1'h0, exec_fault_i = 1'h0;
    logic        user_save_req_i = 1'h0, user_save_wp_i = 1'h0, copy_req_i = 1'h0;
    logic        enc_wiring_det_i = 1'h0, enc_signal_det_i = 1'h0, pready_o, pslverr_o;
    logic        pwm_enable_o, fault_active_o, overcurrent_pin_i, ext_alarm_pin_i;
    logic        ext_fault_pin_i, keypad_link_ok_i;
    logic [7:0]  paddr_i = '0, user_diff_count_i = '0, copy_ver_i = 8'h12, own_ver_i = 8'h12;
    logic [15:0] stator_res_i = '0, stator_res_max_i = 16'h01f4, speed_ref_i = 16'h05dc;
    logic [15:0] out_speed_i = 16'h05d2, link_voltage_i, out_current_i, out_freq_i, module_temp_i;
    logic [31:0] pwdata_i = '0, prdata_o;
    int          num_errors = 0, compares = 0, cycles = 0;
    ifs_plant_model plant (.oc_o(overcurrent_pin_i), .volt_o(link_voltage_i),
        .alarm_pin_o(ext_alarm_pin_i), .fault_pin_o(ext_fault_pin_i), .link_ok_o(keypad_link_ok_i),
        .meas_o({out_current_i, out_freq_i, module_temp_i}));
    ifs_supervisor dut (.*);
    always #12.5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) if (++cycles == 20000) begin
        num_errors++;
        summarize();
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            num_errors++;
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge ref_clk_i);
        {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'h1, wr, a, d};
        @(posedge ref_clk_i);
        penable_i <= 1'h1;
        do @(posedge ref_clk_i); while (pready_o !== 1'h1 && ++n < 50);
        {psel_i, penable_i} <= 2'h0;
        chk($sformatf("error %h", a), {31'h0, a > OFS_CONTROL}, {31'h0, pslverr_o});
        if (!wr && a <= OFS_CONTROL) chk($sformatf("reg %h", a), d, prdata_o);
        if (n == 50) num_errors++;
    endtask : bus
    task automatic expect_trip(input logic [15:0] code);
        repeat (8) @(posedge ref_clk_i);
        bus(1'h0, OFS_FAULT, {16'h0, code});
        chk("pwm enable", '0, pwm_enable_o);
        chk("fault active", 32'h1, fault_active_o);
    endtask : expect_trip
    // The cause must be gone first, or the fault latches straight back
    task automatic clear(input logic hi);
        repeat (8) @(posedge ref_clk_i);
        bus(1'h1, OFS_CONTROL, {30'h0, 1'h1, hi});
        repeat (4) @(posedge ref_clk_i);
        chk("pwm after clear", 32'h1, pwm_enable_o);
        chk("fault after clear", '0, fault_active_o);
    endtask : clear
    task automatic t_regs;
        bus(1'h0, OFS_AR_DELAY, '0);
        bus(1'h1, OFS_AR_DELAY, 32'h1ff);
        bus(1'h0, OFS_AR_DELAY, 32'hff);
        bus(1'h1, OFS_AR_DELAY, '0);
        bus(1'h0, OFS_ENC_MASK, 32'h3);
        bus(1'h1, OFS_LAST, 32'h1234);
        bus(1'h0, OFS_LAST, '0);
        bus(1'h1, OFS_SPD_REF, 32'h1234);
        bus(1'h0, OFS_SPD_REF, 32'h05dc);
        bus(1'h0, 8'h3c, '0);
    endtask : t_regs
    task automatic t_overcurrent;
        plant.c_oc <= 1'h1;
        expect_trip(F_OVERCURR);
        bus(1'h0, OFS_CURR, 32'h007b);
        bus(1'h0, OFS_FREQ, 32'h0258);
        plant.c_oc <= 1'h0;
        clear(1'h0);
    endtask : t_overcurrent
    task automatic link_trip(input logic [15:0] v, input logic [15:0] code, input logic hi);
        plant.c_volt <= v;
        expect_trip(code);
        bus(1'h0, OFS_VOLT, {16'h0, v});
        plant.c_volt <= 16'h012c;
        clear(hi);
    endtask : link_trip
    // 411 V only trips on the high supply range, so the range select shows
    task automatic t_link;
        link_trip(16'h00e5, F_LINK_LOW, 1'h0);
        link_trip(16'h01cd, F_LINK_HIGH, 1'h0);
        bus(1'h0, OFS_LAST, {16'h0, F_LINK_HIGH});
        bus(1'h0, OFS_SECOND, {16'h0, F_LINK_LOW});
        bus(1'h0, OFS_THIRD, {16'h0, F_OVERCURR});
        bus(1'h1, OFS_CONTROL, 32'h1);
        link_trip(16'h00c7, F_LINK_LOW, 1'h1);
        link_trip(16'h019b, F_LINK_HIGH, 1'h1);
        bus(1'h1, OFS_CONTROL, '0);
    endtask : t_link
    task automatic t_inputs;
        {ext_alarm_en_i, ext_fault_en_i} <= 2'h3;
        plant.c_alarm <= 1'h0;
        repeat (8) @(posedge ref_clk_i);
        bus(1'h0, OFS_ALARM, {16'h0, A_EXT});
        chk("pwm with alarm", 32'h1, pwm_enable_o);
        {plant.c_alarm, plant.c_fault} <= 2'h2;
        expect_trip(F_EXT);
        plant.c_fault <= 1'h1;
        clear(1'h0);
        plant.c_link <= 1'h0;
        repeat (8) @(posedge ref_clk_i);
        bus(1'h0, OFS_ALARM, {16'h0, A_KEYPAD});
        keypad_is_source_i <= 1'h1;
        expect_trip(F_KEYPAD);
        plant.c_link <= 1'h1;
        clear(1'h0);
    endtask : t_inputs
    task automatic ev(input logic [7:0] c, input logic [15:0] code);
        {tuning_done_i, stator_res_edit_i, hw_identify_fail_i, user_save_req_i, copy_req_i,
         exec_fault_i, enc_wiring_det_i, enc_signal_det_i} <= c;
        expect_trip(code);
        {tuning_done_i, stator_res_edit_i, hw_identify_fail_i, user_save_req_i, copy_req_i,
         exec_fault_i, enc_wiring_det_i, enc_signal_det_i} <= 8'h0;
        clear(1'h0);
    endtask : ev
    // Qualifying levels stand throughout; each step raises only its event, except the signal step, which also raises the masked wiring input
    task automatic t_events;
        {tuning_mode_vv_i, default_load_i, user_diff_count_i, copy_ver_i} <= {2'h3, 8'd33, 8'h22};
        stator_res_i <= 16'h01f5;
        ev(8'h80, F_TUNING);
        ev(8'h40, F_TUNING);
        ev(8'h20, F_HW_ID);
        ev(8'h10, F_USER_SAVE);
        ev(8'h08, F_COPY);
        ev(8'h04, F_EXEC);
        ev(8'h02, F_ENC_WIRING);
        bus(1'h1, OFS_ENC_MASK, 32'h2);
        ev(8'h03, F_ENC_SIGNAL);
        bus(1'h1, OFS_ENC_MASK, 32'h0);
        {enc_wiring_det_i, enc_signal_det_i} <= 2'h3;
        repeat (8) @(posedge ref_clk_i);
        chk("masked encoder", '0, fault_active_o);
        {enc_wiring_det_i, enc_signal_det_i} <= 2'h0;
    endtask : t_events
    task automatic summarize;
        if (num_errors == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    initial begin
        repeat (12) @(posedge ref_clk_i);
        nrst_i <= 1'h1;
        repeat (4) @(posedge ref_clk_i);
        t_regs();
        t_overcurrent();
        t_link();
        t_inputs();
        t_events();
        summarize();
    end
endmodule : tb_inverter_fault_supervisor
`default_nettype wire
